/* pkg/slot_decode_defs.svh */
`ifndef SLOT_DECODE_DEFS_SVH
`define SLOT_DECODE_DEFS_SVH

// Address layout of the backplane byte address
`define ADDR_W 32
`define SUPER_NIBBLE 4'hf
`define TOP_MSB 31
`define TOP_LSB 28
`define ID_MSB 27
`define ID_LSB 24
`define OFS_MSB 23
`define OFS_LSB 0
`define LANE_MSB 1
`define LANE_LSB 0

// Offsets inside the card's 16 Mbyte slot region
`define DRAM_FIRST 24'h000000
`define DRAM_LAST 24'h00ffff
`define ROM_FIRST 24'hf80000
`define ROM_LAST 24'hf803fc

// Memory sizes behind the decoder
`define DRAM_WORDS 262144
`define DRAM_WORD_W 32
`define ROM_BYTES 1024

`endif

/* pkg/slot_decode_pkg.sv */
package slot_decode_pkg;
  typedef enum logic [1:0] {
    region_none,
    region_dram,
    region_rom,
    region_invalid
  } region_t;
endpackage

/* hdl/range_match.sv */
`timescale 1ns/10ps
// ************************************************************
// Inclusive range compare
// ************************************************************
module range_match #(
  parameter int W = 24,
  parameter logic [W-1:0] FIRST = '0,
  parameter logic [W-1:0] LAST = '1
) (
  input wire logic [W-1:0] value,
  output logic hit
);
  assign hit = (value >= FIRST) && (value <= LAST);
endmodule

/* hdl/pin_sync.sv */
`timescale 1ns/10ps
// ************************************************************
// Two-stage synchroniser for pin levels
// ************************************************************
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  always_comb begin
    next_stage1 = din;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign dout = stage2;
endmodule

/* hdl/slot_space_address_decoder.sv */
`timescale 1ns/10ps
// Contract
// - Accept a full 32-bit byte address covering 4 Gbyte.
// - Top nibble F marks the 256 Mbyte super-slot space.
// - Super-slot space splits into 16 slot regions of 16 Mbyte.
// - Region selected when top nibble F and next nibble equals slot ID.
// - Drive active-low slot match whenever a valid address is in own slot and bus reset is high.
// - Offsets 000000-00ffff are DRAM; f80000-f803fc are ROM.
// - Any other offset in own slot is invalid.
// - Low two address bits never select a region; passed on for lanes.
// - With a valid address present, drive the two select outputs.
// - ROM select low for ROM range, high otherwise.
// - DRAM select low for DRAM range, high otherwise.
// - Slave only; never starts a bus transaction.
// - DRAM is 256K words of 32 bits; ROM holds 1 Kbyte.
`include "slot_decode_defs.svh"
module slot_space_address_decoder #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DRAM_WORDS = `DRAM_WORDS,
  parameter int ROM_BYTES = `ROM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic addr_valid,
  input wire logic [3:0] slot_id,
  input wire logic latched_write_flag,
  input wire logic latched_bus_reset_n,
  output logic slot_id_match_n,
  output logic dram_sel_n,
  output logic rom_sel_n,
  output logic addr_invalid,
  output logic rom_write_err,
  output logic [1:0] byte_lane,
  output logic [17:0] dram_word_addr,
  output logic [7:0] rom_word_addr,
  output logic bus_request
);

  // Word address widths follow the memory sizes
  localparam int DRAM_AW = $clog2(DRAM_WORDS);
  localparam int ROM_AW = $clog2(ROM_BYTES) - 2;

  // ************************************************************
  // Input capture
  // ************************************************************
  // Backplane signals come from outside the clock's domain.
  logic [ADDR_W-1:0] addr_s;
  logic valid_s;
  logic [3:0] id_s;
  logic wr_s;
  logic brst_n_s;

  pin_sync #(.W(ADDR_W), .INIT('0)) u_addr_sync (
    .clk(clk),
    .rst(rst),
    .din(bus_addr),
    .dout(addr_s)
  );

  pin_sync #(.W(7), .INIT(7'h00)) u_ctl_sync (
    .clk(clk),
    .rst(rst),
    .din({addr_valid, slot_id, latched_write_flag, latched_bus_reset_n}),
    .dout({valid_s, id_s, wr_s, brst_n_s})
  );

  // ************************************************************
  // Slot compare
  // ************************************************************
  logic in_super;
  logic in_slot;
  logic [23:0] offset;
  logic [23:0] word_ofs;
  logic dram_hit;
  logic rom_hit;

  assign in_super = addr_s[`TOP_MSB:`TOP_LSB] == `SUPER_NIBBLE;
  assign offset = addr_s[`OFS_MSB:`OFS_LSB];
  // lane bits play no part in the region choice
  assign word_ofs = {offset[23:`LANE_MSB+1], 2'h0};

  always_comb begin
    in_slot = valid_s && brst_n_s && in_super &&
              (addr_s[`ID_MSB:`ID_LSB] == id_s);
  end

  range_match #(.W(24), .FIRST(`DRAM_FIRST), .LAST(`DRAM_LAST)) u_dram (
    .value(word_ofs),
    .hit(dram_hit)
  );

  range_match #(.W(24), .FIRST(`ROM_FIRST), .LAST(`ROM_LAST)) u_rom (
    .value(word_ofs),
    .hit(rom_hit)
  );

  // ************************************************************
  // Region classification
  // ************************************************************
  slot_decode_pkg::region_t next_region;

  always_comb begin
    // anything else in slot is invalid
    if (!in_slot) begin
      next_region = slot_decode_pkg::region_none;
    end else if (dram_hit) begin
      next_region = slot_decode_pkg::region_dram;
    end else if (rom_hit) begin
      next_region = slot_decode_pkg::region_rom;
    end else begin
      next_region = slot_decode_pkg::region_invalid;
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  logic next_match_n;
  logic next_dram_n;
  logic next_rom_n;
  logic next_invalid;
  logic next_rom_wr;
  logic [1:0] next_lane;
  logic [17:0] next_dram_addr;
  logic [7:0] next_rom_addr;

  always_comb begin
    next_match_n = !in_slot;
    next_dram_n = next_region != slot_decode_pkg::region_dram;
    next_rom_n = next_region != slot_decode_pkg::region_rom;
    next_invalid = next_region == slot_decode_pkg::region_invalid;
    // Helper flag; sequencer makes the final call on a ROM write
    next_rom_wr = (next_region == slot_decode_pkg::region_rom) && wr_s;
    next_lane = addr_s[`LANE_MSB:`LANE_LSB];
    // word index into 256K x 32 and 1K byte ROM
    next_dram_addr = addr_s[DRAM_AW+1:2];
    next_rom_addr = addr_s[ROM_AW+1:2];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slot_id_match_n <= 1'b1;
      dram_sel_n <= 1'b1;
      rom_sel_n <= 1'b1;
      addr_invalid <= 1'b0;
      rom_write_err <= 1'b0;
      byte_lane <= 2'h0;
      dram_word_addr <= 18'h00000;
      rom_word_addr <= 8'h00;
    end else begin
      slot_id_match_n <= next_match_n;
      dram_sel_n <= next_dram_n;
      rom_sel_n <= next_rom_n;
      addr_invalid <= next_invalid;
      rom_write_err <= next_rom_wr;
      byte_lane <= next_lane;
      dram_word_addr <= next_dram_addr;
      rom_word_addr <= next_rom_addr;
    end
  end

  // slave only, never requests the bus
  assign bus_request = 1'b0;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_dram_sel;
    @(posedge clk) disable iff (rst)
      (valid_s && brst_n_s && in_super && addr_s[27:24] == id_s &&
       offset <= 24'h00ffff) |=> !dram_sel_n && rom_sel_n;
  endproperty
  a_dram_sel: assert property (p_dram_sel)
    else $error("dram select missing");

  property p_rom_sel;
    @(posedge clk) disable iff (rst)
      (in_slot && offset >= 24'hf80000 && offset <= 24'hf803fc)
      |=> !rom_sel_n && dram_sel_n;
  endproperty
  a_rom_sel: assert property (p_rom_sel)
    else $error("rom select missing");

  property p_outside;
    @(posedge clk) disable iff (rst)
      !in_slot |=> dram_sel_n && rom_sel_n && slot_id_match_n;
  endproperty
  a_outside: assert property (p_outside)
    else $error("select outside slot");

  property p_match;
    @(posedge clk) disable iff (rst)
      in_slot |=> !slot_id_match_n;
  endproperty
  a_match: assert property (p_match) else $error("slot match missing");

  property p_invalid;
    @(posedge clk) disable iff (rst)
      (in_slot && offset == 24'h010000) |=>
        addr_invalid && dram_sel_n && rom_sel_n;
  endproperty
  a_invalid: assert property (p_invalid) else $error("gap not invalid");

  property p_rom_edge;
    @(posedge clk) disable iff (rst)
      (in_slot && offset == 24'hf80400) |=> rom_sel_n;
  endproperty
  a_rom_edge: assert property (p_rom_edge) else $error("rom end off");

  property p_super;
    @(posedge clk) disable iff (rst)
      (addr_s[31:28] != 4'hf) |=> slot_id_match_n;
  endproperty
  a_super: assert property (p_super) else $error("non super matched");

  property p_lane;
    @(posedge clk) disable iff (rst)
      1'b1 |=> byte_lane == $past(addr_s[1:0]);
  endproperty
  a_lane: assert property (p_lane) else $error("lane bits lost");

  property p_onehot;
    @(posedge clk) disable iff (rst)
      !(dram_sel_n == 1'b0 && rom_sel_n == 1'b0);
  endproperty
  a_onehot: assert property (p_onehot) else $error("both selects low");

  property p_slave;
    @(posedge clk) disable iff (rst) bus_request == 1'b0;
  endproperty
  a_slave: assert property (p_slave) else $error("bus requested");

  // ************************************************************
  // End-to-end checks from the pins
  // ************************************************************
  // Two sync stages and the output register put every answer 3 edges on
  sequence s_pin_own_slot;
    addr_valid && latched_bus_reset_n && bus_addr[31:28] == 4'hf &&
      bus_addr[27:24] == slot_id;
  endsequence

  sequence s_pin_dram;
    s_pin_own_slot ##0 (bus_addr[23:0] <= 24'h00ffff);
  endsequence

  sequence s_pin_gap;
    s_pin_own_slot ##0
      (bus_addr[23:0] > 24'h00ffff && bus_addr[23:0] < 24'hf80000);
  endsequence

  sequence s_pin_rom;
    s_pin_own_slot ##0
      (bus_addr[23:0] >= 24'hf80000 && bus_addr[23:0] <= 24'hf803ff);
  endsequence

  sequence s_out_idle;
    slot_id_match_n && dram_sel_n && rom_sel_n && !addr_invalid;
  endsequence

  property p_pin_match;
    @(posedge clk) disable iff (rst)
      s_pin_own_slot |-> ##3 !slot_id_match_n;
  endproperty
  a_pin_match: assert property (p_pin_match) else $error("no match");

  property p_pin_dram;
    @(posedge clk) disable iff (rst)
      s_pin_dram |-> ##3 (!dram_sel_n && rom_sel_n && !addr_invalid);
  endproperty
  a_pin_dram: assert property (p_pin_dram) else $error("no dram");

  property p_pin_rom;
    @(posedge clk) disable iff (rst)
      s_pin_rom |-> ##3 (!rom_sel_n && dram_sel_n && !addr_invalid);
  endproperty
  a_pin_rom: assert property (p_pin_rom) else $error("no rom");

  property p_pin_write;
    @(posedge clk) disable iff (rst)
      s_pin_rom ##0 latched_write_flag |-> ##3 (rom_write_err && !rom_sel_n);
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("no flag");

  property p_pin_gap;
    @(posedge clk) disable iff (rst)
      s_pin_gap |-> ##3
        (addr_invalid && dram_sel_n && rom_sel_n && !slot_id_match_n);
  endproperty
  a_pin_gap: assert property (p_pin_gap) else $error("gap missed");

  property p_pin_no_valid;
    @(posedge clk) disable iff (rst)
      !addr_valid |-> ##3 s_out_idle;
  endproperty
  a_pin_no_valid: assert property (p_pin_no_valid)
    else $error("select without valid");

  property p_pin_bus_reset;
    @(posedge clk) disable iff (rst)
      !latched_bus_reset_n |-> ##3 s_out_idle;
  endproperty
  a_pin_bus_reset: assert property (p_pin_bus_reset)
    else $error("select in bus reset");
endmodule

/* test/seq_model.sv */
`timescale 1ns/10ps
// ************************************************************
// Memory sequencer stand-in: classifies each decoded access
// ************************************************************
module seq_model (
  input wire logic clk,
  input wire logic latched_bus_reset_n,
  input wire logic latched_write_flag,
  input wire logic slot_id_match_n,
  input wire logic dram_sel_n,
  input wire logic rom_sel_n,
  output logic [1:0] kind
);
  // Kind codes: 0 idle, 1 DRAM, 2 ROM, 3 invalid
  always_ff @(posedge clk) begin
    if (!latched_bus_reset_n || slot_id_match_n) begin
      kind <= 2'h0;
    end else if ((dram_sel_n && rom_sel_n) ||
                 (!rom_sel_n && latched_write_flag)) begin
      kind <= 2'h3;
    end else begin
      kind <= dram_sel_n ? 2'h2 : 2'h1;
    end
  end
endmodule

/* test/tb_slot_space_address_decoder.sv */
`timescale 1ns/10ps
module tb_slot_space_address_decoder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] bus_addr = 32'h0;
  logic addr_valid = 1'b0;
  logic [3:0] slot_id = 4'h5;
  logic latched_write_flag = 1'b0;
  logic latched_bus_reset_n = 1'b1;
  logic slot_id_match_n, dram_sel_n, rom_sel_n, addr_invalid;
  logic rom_write_err, bus_request;
  logic [1:0] byte_lane, kind;
  logic [17:0] dram_word_addr;
  logic [7:0] rom_word_addr;
  logic [4:0] flags;
  int err_total = 0;
  int checked = 0;
  initial forever #50 clk = ~clk;
  assign flags = {slot_id_match_n, dram_sel_n, rom_sel_n, addr_invalid,
                  rom_write_err};
  slot_space_address_decoder slot_space_address_decoder_i (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .addr_valid(addr_valid),
    .slot_id(slot_id), .latched_write_flag(latched_write_flag),
    .latched_bus_reset_n(latched_bus_reset_n),
    .slot_id_match_n(slot_id_match_n), .dram_sel_n(dram_sel_n),
    .rom_sel_n(rom_sel_n), .addr_invalid(addr_invalid),
    .rom_write_err(rom_write_err), .byte_lane(byte_lane),
    .dram_word_addr(dram_word_addr), .rom_word_addr(rom_word_addr),
    .bus_request(bus_request));
  seq_model seq_model_i (.clk(clk), .latched_bus_reset_n(latched_bus_reset_n),
    .latched_write_flag(latched_write_flag),
    .slot_id_match_n(slot_id_match_n), .dram_sel_n(dram_sel_n),
    .rom_sel_n(rom_sel_n), .kind(kind));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Outputs settle 3 edges after the inputs; one more lets kind follow
  task automatic go(input logic [31:0] a, input logic v, w);
    bus_addr = a;
    addr_valid = v;
    latched_write_flag = w;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_dram();
    go(32'hf5000007, 1'b1, 1'b0);
    chk(32'(flags), 32'h04, "dram flags");
    chk(32'(byte_lane), 32'h3, "lane");
    chk(32'(dram_word_addr), 32'h1, "dram word");
    chk(32'(kind), 32'h1, "kind");
    go(32'hf500fffc, 1'b1, 1'b1);
    chk(32'(flags), 32'h04, "dram top");
    chk(32'(dram_word_addr), 32'h3fff, "dram last");
  endtask
  task automatic t_rom();
    go(32'hf5f803fc, 1'b1, 1'b0);
    chk(32'(flags), 32'h08, "rom flags");
    chk(32'(rom_word_addr), 32'hff, "rom word");
    chk(32'(kind), 32'h2, "kind");
    go(32'hf5f803ff, 1'b1, 1'b0);
    chk(32'(flags), 32'h08, "rom lane bits");
    chk(32'(byte_lane), 32'h3, "rom lane");
    go(32'hf5f80400, 1'b1, 1'b0);
    chk(32'(flags), 32'h0e, "rom past end");
    go(32'hf5f80000, 1'b1, 1'b1);
    chk(32'(flags), 32'h09, "rom write");
    chk(32'(kind), 32'h3, "kind");
  endtask
  task automatic t_gap();
    go(32'hf5010000, 1'b1, 1'b0);
    chk(32'(flags), 32'h0e, "gap");
    chk(32'(kind), 32'h3, "kind");
    go(32'hf5f7fffc, 1'b1, 1'b0);
    chk(32'(flags), 32'h0e, "below rom");
  endtask
  task automatic t_miss();
    go(32'hf6000000, 1'b1, 1'b0);
    chk(32'(flags), 32'h1c, "other slot");
    go(32'he5000000, 1'b1, 1'b0);
    chk(32'(flags), 32'h1c, "not super");
    slot_id = 4'ha;
    go(32'hfa000000, 1'b1, 1'b0);
    chk(32'(flags), 32'h04, "new slot");
    slot_id = 4'h5;
  endtask
  task automatic t_gate();
    go(32'hf5000000, 1'b0, 1'b0);
    chk(32'(flags), 32'h1c, "no valid");
    latched_bus_reset_n = 1'b0;
    go(32'hf5000000, 1'b1, 1'b0);
    chk(32'(flags), 32'h1c, "bus reset");
    chk(32'(kind), 32'h0, "idle");
    latched_bus_reset_n = 1'b1;
    chk(32'(bus_request), 32'h0, "slave only");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_dram();
    t_rom();
    t_gap();
    t_miss();
    t_gate();
    test_done();
  end
endmodule
